// ---- core/asfifo_consts.svh ----
// register offsets, field positions, reset values and timing constants
`ifndef ASFIFO_CONSTS_SVH
`define ASFIFO_CONSTS_SVH
`define ASF_OFF_CON 12'h000
`define ASF_OFF_BAUD 12'h004
`define ASF_OFF_TXBUF 12'h008
`define ASF_OFF_RXBUF 12'h00c
`define ASF_OFF_TX_FIFO_CONTROL 12'h010
`define ASF_OFF_RX_FIFO_CONTROL 12'h014
`define ASF_OFF_FSTAT 12'h018
`define ASF_OFF_FLAGS 12'h01c
`define ASF_CON_RUN 0
`define ASF_CON_REN 1
`define ASF_CON_NINE 2
`define ASF_CON_STOP2 3
`define ASF_CON_WAKE 4
`define ASF_CON_OEN 5
`define ASF_FCON_EN 0
`define ASF_FCON_FLUSH 1
`define ASF_FCON_LVL_LO 8
`define ASF_BAUD_RESET 13'h0001
`define ASF_OVS 5'd16
`define ASF_VOTE_A 4'd6
`define ASF_VOTE_B 4'd7
`define ASF_VOTE_C 4'd8
`endif

// ---- core/asfifo_pkg.sv ----
// types shared by the serial channel
package asfifo_pkg;
  typedef enum logic [1:0] {
    ASF_TX_IDLE = 2'b00,
    ASF_TX_START = 2'b01,
    ASF_TX_DATA = 2'b10,
    ASF_TX_STOP = 2'b11
  } asfifo_tx_t;
  typedef enum logic [1:0] {
    ASF_RX_IDLE = 2'b00,
    ASF_RX_START = 2'b01,
    ASF_RX_DATA = 2'b10,
    ASF_RX_STOP = 2'b11
  } asfifo_rx_t;
endpackage

// ---- core/asfifo_serial_channel.sv ----
// serial channel with transmit and receive queues behind an APB slave
// Function
// - frame starts at next baud tick when running and data is waiting
// - frame: start bit, 8 or 9 data bits lsb first, 1 or 2 stops
// - idle shifter and empty holding stage: written byte enters holding stage at once, pulses tx buffer irq
// - tx done irq raised before the final stop bit leaves
// - eight entry tx queue, only when enabled, filled only via tx buffer
// - with tx queue, tx irqs fire when fill level at or below trigger
// - status field shows tx fill level
// - write with empty queue, empty holding stage and idle shifter bypasses the queue
// - write to full tx queue flags overrun, overwrites last entry
// - tx flush empties queue, running frame continues
// - tx queue flushed on reset and when enable is cleared
// - reception starts on falling edge when run and receive enable set
// - sixteen samples per bit, vote of samples seven, eight, nine
// - start bit not voted zero abandons the frame
// - frame stored and rx irq after ninth sample of last stop bit
// - clearing receive enable lets the current frame finish
// - wake mode keeps only frames whose ninth bit is one
// - eight entry rx queue, rx irq when fill at or above trigger
// - status field shows rx fill; bytes leave only via rx buffer reads
// - byte into full rx queue: rx and error irq, overwrite last entry
// - read of empty enabled rx queue flags overrun, level stays zero
// - rx queue disabled means plain double buffered receiver
// - rx queue flushed by flush, reset, disable; not by receive enable
// - unread buffer overwritten with overrun when checking enabled
`timescale 1ns/1ps
`include "asfifo_consts.svh"
module asfifo_serial_channel
  import asfifo_pkg::*;
#(
  parameter int DEPTH = 8
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RXD,
  output logic TXD,
  output logic TX_BUFFER_IRQ,
  output logic TX_DONE_IRQ,
  output logic RX_IRQ,
  output logic ERROR_IRQ
);
  // queue indexing and fill width only serve eight entries
  if (DEPTH != 8) begin : g_depth_check
    $error("depth must be 8");
  end
  localparam int LW = 4;
  // control registers
  logic [5:0] ctrl, next_ctrl;
  logic [12:0] baud_reload, next_baud_reload;
  logic tx_fifo_enable, next_tx_fifo_enable;
  logic rx_fifo_enable, next_rx_fifo_enable;
  logic [3:0] tx_trigger_level, next_tx_trigger_level;
  logic [3:0] rx_trigger_level, next_rx_trigger_level;
  logic overrun, next_overrun;
  // tx state
  asfifo_tx_t tx_st, next_tx_st;
  logic [8:0] tx_shift, next_tx_shift;
  logic [3:0] tx_bit, next_tx_bit;
  logic tx_hold, next_tx_hold;
  logic [8:0] tx_hold_data, next_tx_hold_data;
  logic [8:0] tx_queue [DEPTH];
  logic [8:0] next_tx_queue [DEPTH];
  logic [LW-1:0] tx_fill_level, next_tx_fill_level;
  logic txd_q, next_txd_q;
  // rx state
  asfifo_rx_t rx_st, next_rx_st;
  logic [8:0] rx_shift, next_rx_shift;
  logic [3:0] rx_bit, next_rx_bit;
  logic [3:0] rx_sub, next_rx_sub;
  logic [2:0] votes, next_votes;
  logic [8:0] rx_queue [DEPTH];
  logic [8:0] next_rx_queue [DEPTH];
  logic [LW-1:0] rx_fill_level, next_rx_fill_level;
  logic [8:0] rx_buffer_reg, next_rx_buffer_reg;
  logic rx_full, next_rx_full;
  // baud timer, pins, bus response, irq pulses and enable delays
  logic [12:0] baud_cnt, next_baud_cnt;
  logic [3:0] div16, next_div16;
  logic rxd_s1, rxd_s2, rxd_prev;
  logic [31:0] prdata_q, next_prdata_q;
  logic pready_q, next_pready_q;
  logic tx_buffer_irq, tx_done_irq, rx_irq, error_irq;
  logic tx_en_d, rx_en_d;

  function automatic logic maj(input logic [2:0] v);
    maj = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction

  wire run = ctrl[`ASF_CON_RUN];
  wire ren = ctrl[`ASF_CON_REN];
  wire nine = ctrl[`ASF_CON_NINE];
  wire stop2 = ctrl[`ASF_CON_STOP2];
  wire wake = ctrl[`ASF_CON_WAKE];
  wire overrun_check_enable = ctrl[`ASF_CON_OEN];
  // one wait state: read data is registered in the first access cycle,
  // so side effects only commit at the edge that sees PREADY high
  wire acc = PSEL & PENABLE;
  wire xfer = acc & pready_q;
  wire wr = xfer & PWRITE;
  wire rd = acc & ~PWRITE;
  wire wr_tx = wr & hit(PADDR, `ASF_OFF_TXBUF);
  wire rd_rx = xfer & ~PWRITE & hit(PADDR, `ASF_OFF_RXBUF);
  wire wr_txf = wr & hit(PADDR, `ASF_OFF_TX_FIFO_CONTROL);
  wire wr_rxf = wr & hit(PADDR, `ASF_OFF_RX_FIFO_CONTROL);
  wire wr_flg = wr & hit(PADDR, `ASF_OFF_FLAGS);
  wire tx_flush = wr_txf & PWDATA[`ASF_FCON_FLUSH];
  wire rx_flush = wr_rxf & PWDATA[`ASF_FCON_FLUSH];
  // 16x tick from reload counter, bit tick every 16
  wire os_tick = run & (baud_cnt == 13'h0000);
  wire bit_tick = os_tick & (div16 == 4'hf);
  wire [3:0] nbits = nine ? 4'd9 : 4'd8;
  wire [3:0] nstops = stop2 ? 4'd2 : 4'd1;
  wire tx_waiting = tx_hold | (tx_fifo_enable & (tx_fill_level != '0));

  // baud timer
  always_comb begin
    next_baud_cnt = baud_cnt;
    next_div16 = div16;
    if (!run) begin
      next_baud_cnt = baud_reload;
      next_div16 = 4'h0;
    end else if (os_tick) begin
      next_baud_cnt = baud_reload;
      next_div16 = div16 + 4'h1;
    end else begin
      next_baud_cnt = baud_cnt - 13'h0001;
    end
  end

  // transmit path: holding stage, queue and shifter
  always_comb begin
    next_tx_st = tx_st;
    next_tx_shift = tx_shift;
    next_tx_bit = tx_bit;
    next_tx_hold = tx_hold;
    next_tx_hold_data = tx_hold_data;
    next_tx_queue = tx_queue;
    next_tx_fill_level = tx_fill_level;
    next_txd_q = txd_q;
    tx_buffer_irq = 1'b0;
    tx_done_irq = 1'b0;
    error_irq = 1'b0;
    // shifter advances on bit ticks
    if (bit_tick) begin
      unique case (tx_st)
        ASF_TX_IDLE: begin
          if (tx_waiting) begin
            next_tx_st = ASF_TX_START;
            next_txd_q = 1'b0;
            if (tx_hold) begin
              next_tx_shift = tx_hold_data;
              next_tx_hold = 1'b0;
            end else begin
              next_tx_shift = tx_queue[0];
              for (int i = 0; i < DEPTH - 1; i++) begin
                next_tx_queue[i] = tx_queue[i + 1];
              end
              next_tx_fill_level = tx_fill_level - 4'd1;
              if (tx_fill_level - 4'd1 <= tx_trigger_level) begin
                tx_buffer_irq = 1'b1;
              end
            end
          end
        end
        ASF_TX_START: begin
          next_tx_st = ASF_TX_DATA;
          next_txd_q = tx_shift[0];
          next_tx_shift = {1'b0, tx_shift[8:1]};
          next_tx_bit = 4'd1;
        end
        ASF_TX_DATA: begin
          if (tx_bit == nbits) begin
            next_tx_st = ASF_TX_STOP;
            next_txd_q = 1'b1;
            next_tx_bit = 4'd1;
            if (!tx_fifo_enable || tx_fill_level <= tx_trigger_level) begin
              tx_done_irq = 1'b1;
            end
          end else begin
            next_txd_q = tx_shift[0];
            next_tx_shift = {1'b0, tx_shift[8:1]};
            next_tx_bit = tx_bit + 4'd1;
          end
        end
        ASF_TX_STOP: begin
          if (tx_bit == nstops) begin
            next_tx_st = ASF_TX_IDLE;
          end else begin
            next_tx_bit = tx_bit + 4'd1;
          end
        end
      endcase
    end
    // software write into buffer or queue
    if (tx_flush || (tx_en_d && !tx_fifo_enable)) begin
      next_tx_fill_level = '0;
    end else if (wr_tx) begin
      if (!tx_fifo_enable) begin
        next_tx_hold_data = PWDATA[8:0];
        next_tx_hold = 1'b1;
        if (tx_st == ASF_TX_IDLE && !tx_hold) begin
          tx_buffer_irq = 1'b1;
        end
      end else if (!tx_hold && next_tx_fill_level == '0 &&
                   tx_st == ASF_TX_IDLE) begin
        next_tx_hold_data = PWDATA[8:0];
        next_tx_hold = 1'b1;
        tx_buffer_irq = 1'b1;
      end else if (next_tx_fill_level == 4'(DEPTH)) begin
        next_tx_queue[DEPTH - 1] = PWDATA[8:0];
        error_irq = 1'b1;
      end else begin
        next_tx_queue[next_tx_fill_level[2:0]] = PWDATA[8:0];
        next_tx_fill_level = next_tx_fill_level + 4'd1;
      end
    end
  end

  // receive path
  always_comb begin
    next_rx_st = rx_st;
    next_rx_shift = rx_shift;
    next_rx_bit = rx_bit;
    next_rx_sub = rx_sub;
    next_votes = votes;
    next_rx_queue = rx_queue;
    next_rx_fill_level = rx_fill_level;
    next_rx_buffer_reg = rx_buffer_reg;
    next_rx_full = rx_full;
    rx_irq = 1'b0;
    if (rd_rx) begin
      if (rx_fifo_enable) begin
        if (rx_fill_level != '0) begin
          for (int i = 0; i < DEPTH - 1; i++) begin
            next_rx_queue[i] = rx_queue[i + 1];
          end
          next_rx_fill_level = rx_fill_level - 4'd1;
        end
      end else begin
        next_rx_full = 1'b0;
      end
    end
    if (rx_st == ASF_RX_IDLE) begin
      if (run && ren && rxd_prev && !rxd_s2) begin
        next_rx_st = ASF_RX_START;
        next_rx_sub = 4'd1;
        next_rx_bit = 4'd0;
      end
    end else if (os_tick) begin
      next_rx_sub = rx_sub + 4'd1;
      if (rx_sub == `ASF_VOTE_A) next_votes[0] = rxd_s2;
      if (rx_sub == `ASF_VOTE_B) next_votes[1] = rxd_s2;
      if (rx_sub == `ASF_VOTE_C) begin
        next_votes[2] = rxd_s2;
        unique case (rx_st)
          ASF_RX_START: begin
            if (maj({rxd_s2, votes[1:0]})) begin
              next_rx_st = ASF_RX_IDLE;
            end
          end
          ASF_RX_DATA: begin
            next_rx_shift = {maj({rxd_s2, votes[1:0]}), rx_shift[8:1]};
            next_rx_bit = rx_bit + 4'd1;
          end
          ASF_RX_STOP: begin
            if (rx_bit == nstops) begin
              // store at ninth sample of last stop bit
              next_rx_st = ASF_RX_IDLE;
              if (!wake || rx_shift[8]) begin
                rx_irq = 1'b1;
                if (rx_fifo_enable) begin
                  if (rx_fill_level == 4'(DEPTH)) begin
                    next_rx_queue[DEPTH - 1] = rx_shift;
                  end else begin
                    next_rx_queue[next_rx_fill_level[2:0]] = rx_shift;
                    next_rx_fill_level = next_rx_fill_level + 4'd1;
                  end
                end else begin
                  next_rx_buffer_reg = rx_shift;
                  next_rx_full = 1'b1;
                end
              end
            end else begin
              next_rx_bit = rx_bit + 4'd1;
            end
          end
          default: next_rx_st = ASF_RX_IDLE;
        endcase
      end
      if (rx_sub == 4'hf) begin
        if (rx_st == ASF_RX_START) begin
          next_rx_st = ASF_RX_DATA;
        end else if (rx_st == ASF_RX_DATA && rx_bit == nbits) begin
          next_rx_st = ASF_RX_STOP;
          next_rx_bit = 4'd1;
          if (!nine) next_rx_shift = {1'b0, rx_shift[8:1]};
        end
      end
    end
    if (rx_flush || (rx_en_d && !rx_fifo_enable)) begin
      next_rx_fill_level = '0;
    end
  end

  // receive trigger and overrun conditions for queue and buffer modes, underflow for queue mode only
  wire rx_store = rx_irq;
  wire rx_ovf = rx_store & (rx_fifo_enable ? rx_fill_level == 4'(DEPTH)
                                           : rx_full & overrun_check_enable);
  wire rx_under = rd_rx & rx_fifo_enable & (rx_fill_level == '0);
  wire rx_trig = rx_fifo_enable ? (next_rx_fill_level >= rx_trigger_level)
                                : 1'b1;

  // register writes and overrun flag; set wins over clear
  always_comb begin
    next_ctrl = ctrl;
    next_baud_reload = baud_reload;
    next_tx_fifo_enable = tx_fifo_enable;
    next_rx_fifo_enable = rx_fifo_enable;
    next_tx_trigger_level = tx_trigger_level;
    next_rx_trigger_level = rx_trigger_level;
    next_overrun = overrun;
    next_pready_q = acc & ~pready_q; // ready in second access cycle
    if (wr && hit(PADDR, `ASF_OFF_CON)) next_ctrl = PWDATA[5:0];
    if (wr && hit(PADDR, `ASF_OFF_BAUD)) next_baud_reload = PWDATA[12:0];
    if (wr_txf) begin
      next_tx_fifo_enable = PWDATA[`ASF_FCON_EN];
      next_tx_trigger_level = PWDATA[`ASF_FCON_LVL_LO +: 4];
    end
    if (wr_rxf) begin
      next_rx_fifo_enable = PWDATA[`ASF_FCON_EN];
      next_rx_trigger_level = PWDATA[`ASF_FCON_LVL_LO +: 4];
    end
    if (wr_flg && PWDATA[0]) next_overrun = 1'b0;
    if (error_irq || rx_ovf || rx_under) next_overrun = 1'b1;
  end

  // read mux, loaded in the first access cycle
  always_comb begin
    next_prdata_q = '0;
    if (rd) begin
      unique case (PADDR)
        `ASF_OFF_CON: next_prdata_q = {26'h0, ctrl};
        `ASF_OFF_BAUD: next_prdata_q = {19'h0, baud_reload};
        `ASF_OFF_RXBUF: next_prdata_q = {23'h0, rx_fifo_enable ?
                                        rx_queue[0] : rx_buffer_reg};
        `ASF_OFF_TX_FIFO_CONTROL: next_prdata_q = {20'h0, tx_trigger_level,
                                          7'h0, tx_fifo_enable};
        `ASF_OFF_RX_FIFO_CONTROL: next_prdata_q = {20'h0, rx_trigger_level,
                                          7'h0, rx_fifo_enable};
        `ASF_OFF_FSTAT: next_prdata_q = {20'h0, tx_fill_level,
                                         4'h0, rx_fill_level};
        `ASF_OFF_FLAGS: next_prdata_q = {28'h0, tx_hold,
                                         rx_full, 1'b0, overrun};
        default: next_prdata_q = '0;
      endcase
    end
  end

  // state registers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl <= '0;
      baud_reload <= `ASF_BAUD_RESET;
      tx_fifo_enable <= 1'b0;
      rx_fifo_enable <= 1'b0;
      tx_trigger_level <= '0;
      rx_trigger_level <= 4'h1;
      overrun <= 1'b0;
      tx_st <= ASF_TX_IDLE;
      tx_shift <= '0;
      tx_bit <= '0;
      tx_hold <= 1'b0;
      tx_hold_data <= '0;
      tx_queue <= '{default: '0};
      tx_fill_level <= '0;
      txd_q <= 1'b1;
      rx_st <= ASF_RX_IDLE;
      rx_shift <= '0;
      rx_bit <= '0;
      rx_sub <= '0;
      votes <= '0;
      rx_queue <= '{default: '0};
      rx_fill_level <= '0;
      rx_buffer_reg <= '0;
      rx_full <= 1'b0;
      baud_cnt <= '0;
      div16 <= '0;
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
      rxd_prev <= 1'b1;
      prdata_q <= '0;
      pready_q <= 1'b0;
      tx_en_d <= 1'b0;
      rx_en_d <= 1'b0;
      TX_BUFFER_IRQ <= 1'b0;
      TX_DONE_IRQ <= 1'b0;
      RX_IRQ <= 1'b0;
      ERROR_IRQ <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      baud_reload <= next_baud_reload;
      tx_fifo_enable <= next_tx_fifo_enable;
      rx_fifo_enable <= next_rx_fifo_enable;
      tx_trigger_level <= next_tx_trigger_level;
      rx_trigger_level <= next_rx_trigger_level;
      overrun <= next_overrun;
      tx_st <= next_tx_st;
      tx_shift <= next_tx_shift;
      tx_bit <= next_tx_bit;
      tx_hold <= next_tx_hold;
      tx_hold_data <= next_tx_hold_data;
      tx_queue <= next_tx_queue;
      tx_fill_level <= next_tx_fill_level;
      txd_q <= next_txd_q;
      rx_st <= next_rx_st;
      rx_shift <= next_rx_shift;
      rx_bit <= next_rx_bit;
      rx_sub <= next_rx_sub;
      votes <= next_votes;
      rx_queue <= next_rx_queue;
      rx_fill_level <= next_rx_fill_level;
      rx_buffer_reg <= next_rx_buffer_reg;
      rx_full <= next_rx_full;
      baud_cnt <= next_baud_cnt;
      div16 <= next_div16;
      rxd_s1 <= RXD;
      rxd_s2 <= rxd_s1;
      rxd_prev <= rxd_s2;
      prdata_q <= next_prdata_q;
      pready_q <= next_pready_q;
      tx_en_d <= tx_fifo_enable;
      rx_en_d <= rx_fifo_enable;
      TX_BUFFER_IRQ <= tx_buffer_irq;
      TX_DONE_IRQ <= tx_done_irq;
      RX_IRQ <= (rx_irq & rx_trig) | (rx_ovf & rx_fifo_enable);
      ERROR_IRQ <= error_irq | rx_ovf | rx_under;
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = 1'b0;
  assign TXD = txd_q;

  chk_tx_full_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    (wr_tx && tx_fifo_enable && tx_fill_level == 4'(DEPTH) && !tx_flush
     && !bit_tick) |=> (tx_fill_level == 4'(DEPTH) && ERROR_IRQ))
    else $error("tx full write lost level or error");
  chk_tx_flush_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    tx_flush |=> tx_fill_level == '0)
    else $error("tx flush left entries");
  chk_tx_disable: assert property (@(posedge CLK) disable iff (!RST_N)
    (tx_en_d && !tx_fifo_enable) |=> tx_fill_level == '0)
    else $error("tx disable did not flush");
  chk_rx_flush_zero: assert property (@(posedge CLK) disable iff (!RST_N)
    rx_flush |=> rx_fill_level == '0)
    else $error("rx flush left entries");
  chk_rx_under: assert property (@(posedge CLK) disable iff (!RST_N)
    rx_under |=> (ERROR_IRQ && overrun && rx_fill_level == '0))
    else $error("rx underflow not flagged");
  chk_start_low: assert property (@(posedge CLK) disable iff (!RST_N)
    (tx_st == ASF_TX_IDLE && next_tx_st == ASF_TX_START) |=> !TXD)
    else $error("start bit not low");
  chk_tx_gated: assert property (@(posedge CLK) disable iff (!RST_N)
    !run |=> $stable(tx_st))
    else $error("tx moved without run");
  chk_rx_idle_gate: assert property (@(posedge CLK) disable iff (!RST_N)
    (rx_st == ASF_RX_IDLE && !ren) |=> rx_st == ASF_RX_IDLE)
    else $error("rx started while disabled");
  chk_rx_level_max: assert property (@(posedge CLK) disable iff (!RST_N)
    rx_fill_level <= 4'(DEPTH))
    else $error("rx level above depth");
  chk_wake_drop: assert property (@(posedge CLK) disable iff (!RST_N)
    (wake && !rx_shift[8] && rx_st == ASF_RX_STOP) |-> !rx_irq)
    else $error("wake mode stored a data frame");
  cov_tx_frame: cover property (@(posedge CLK) disable iff (!RST_N)
    TX_DONE_IRQ);
  cov_rx_frame: cover property (@(posedge CLK) disable iff (!RST_N)
    RX_IRQ);
  cov_tx_full: cover property (@(posedge CLK) disable iff (!RST_N)
    tx_fill_level == 4'(DEPTH));
endmodule

// ---- sim/asfifo_remote.sv ----
// remote serial station on the transmit and receive lines
`timescale 1ns/1ps
module asfifo_remote #(
  parameter int BIT_NS = 400
) (
  input wire logic TXD,
  output logic RXD
);
  logic [7:0] got[$];
  logic [7:0] sh;
  // line idles high between frames
  initial RXD = 1'b1;
  // one frame: start, data lsb first, one stop
  task automatic send(input logic [8:0] v, input int n);
    RXD = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < n; i++) begin
      RXD = v[i];
      #(BIT_NS);
    end
    RXD = 1'b1;
    #(BIT_NS);
  endtask
  // short low pulse that must not pass as a start bit
  task automatic glitch;
    RXD = 1'b0;
    #100;
    RXD = 1'b1;
  endtask
  // decode eight bit frames from the device at mid bit
  always begin
    @(negedge TXD);
    #(BIT_NS + BIT_NS / 2);
    for (int i = 0; i < 8; i++) begin
      sh[i] = TXD;
      #(BIT_NS);
    end
    got.push_back(sh);
  end
endmodule

// ---- sim/asfifo_serial_channel_tb.sv ----
// register level tests of the serial channel against a remote station
`timescale 1ns/1ps
`include "asfifo_consts.svh"
module asfifo_serial_channel_tb;
  logic clk, rst_n, psel, penable, pwrite, txd, rxd;
  logic pready, pslverr, tbi, tdi, rxi, eri;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] txe [3] = '{8'ha5, 8'h3c, 8'hf0};
  int fails, num_checks, n_tbi, n_tdi, n_rxi, n_eri, c0, n;
  asfifo_serial_channel asfifo_serial_channel_inst (
    .CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .RXD(rxd), .TXD(txd),
    .TX_BUFFER_IRQ(tbi), .TX_DONE_IRQ(tdi), .RX_IRQ(rxi), .ERROR_IRQ(eri)
  );
  asfifo_remote asfifo_remote_inst (.TXD(txd), .RXD(rxd));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // count one-cycle interrupt pulses mid cycle, where they are settled
  always @(negedge clk) begin
    if (tbi === 1'b1) n_tbi++;
    if (tdi === 1'b1) n_tdi++;
    if (rxi === 1'b1) n_rxi++;
    if (eri === 1'b1) n_eri++;
  end
  task check(input string nm, input logic [31:0] seen, input logic [31:0] e);
    num_checks++;
    if (seen !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, seen);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one apb transfer, read data taken at the edge that sees pready high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      fails++;
      test_done();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(string nm, logic [11:0] a, logic [31:0] m, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(nm, rd & m, e);
  endtask
  task tx(input logic [8:0] v, input int b);
    @(negedge clk);
    asfifo_remote_inst.send(v, b);
    repeat (4) @(posedge clk);
  endtask
  // main sequence
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("txd idle", {31'h0, txd}, 32'h1);
    rdc("fill reset", `ASF_OFF_FSTAT, 32'hf0f, 32'h0);
    rdc("rx_fifo_control reset", `ASF_OFF_RX_FIFO_CONTROL, 32'hf03, 32'h100);
    // three bytes out: first bypasses the queue
    wr(`ASF_OFF_CON, 32'h3);
    wr(`ASF_OFF_BAUD, 32'h0);
    wr(`ASF_OFF_TX_FIFO_CONTROL, 32'h1);
    c0 = n_tbi;
    for (int i = 0; i < 3; i++) wr(`ASF_OFF_TXBUF, {24'h0, txe[i]});
    check("tx bypass irq", {31'h0, n_tbi > c0}, 32'h1);
    rdc("tx fill", `ASF_OFF_FSTAT, 32'hf00, 32'h200);
    n = 0;
    while (asfifo_remote_inst.got.size() < 3 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    check("tx frames", asfifo_remote_inst.got.size(), 3);
    for (int i = 0; i < 3; i++) begin
      check("tx byte", {24'h0, asfifo_remote_inst.got[i]}, {24'h0, txe[i]});
    end
    check("tx done irq", {31'h0, n_tdi > 0}, 32'h1);
    // receive queue with trigger three
    wr(`ASF_OFF_RX_FIFO_CONTROL, 32'h301);
    c0 = n_rxi;
    tx(9'h055, 8);
    tx(9'h00f, 8);
    check("rx below trigger", {31'h0, n_rxi == c0}, 32'h1);
    tx(9'h081, 8);
    check("rx at trigger", {31'h0, n_rxi > c0}, 32'h1);
    rdc("rx fill", `ASF_OFF_FSTAT, 32'hf0f, 32'h3);
    rdc("rx data", `ASF_OFF_RXBUF, 32'h1ff, 32'h055);
    rdc("rx data", `ASF_OFF_RXBUF, 32'h1ff, 32'h00f);
    rdc("rx data", `ASF_OFF_RXBUF, 32'h1ff, 32'h081);
    c0 = n_eri;
    apb(1'b0, `ASF_OFF_RXBUF, 32'h0);
    check("underflow irq", {31'h0, n_eri > c0}, 32'h1);
    rdc("underflow flag", `ASF_OFF_FLAGS, 32'h1, 32'h1);
    rdc("rx fill empty", `ASF_OFF_FSTAT, 32'hf0f, 32'h0);
    wr(`ASF_OFF_FLAGS, 32'h1);
    // false start bit
    @(negedge clk);
    asfifo_remote_inst.glitch();
    repeat (400) @(posedge clk);
    rdc("glitch fill", `ASF_OFF_FSTAT, 32'hf0f, 32'h0);
    // wake mode keeps only ninth bit one
    wr(`ASF_OFF_CON, 32'h17);
    tx(9'h0aa, 9);
    tx(9'h155, 9);
    rdc("wake fill", `ASF_OFF_FSTAT, 32'hf0f, 32'h1);
    rdc("wake data", `ASF_OFF_RXBUF, 32'h1ff, 32'h155);
    // receive enable cleared keeps queue contents
    wr(`ASF_OFF_CON, 32'h3);
    tx(9'h066, 8);
    wr(`ASF_OFF_CON, 32'h1);
    tx(9'h077, 8);
    rdc("ren off fill", `ASF_OFF_FSTAT, 32'hf0f, 32'h1);
    wr(`ASF_OFF_RX_FIFO_CONTROL, 32'h0);
    rdc("disable fill", `ASF_OFF_FSTAT, 32'hf0f, 32'h0);
    // plain buffer overrun
    wr(`ASF_OFF_CON, 32'h23);
    tx(9'h011, 8);
    tx(9'h022, 8);
    rdc("buffer overrun", `ASF_OFF_FLAGS, 32'h1, 32'h1);
    rdc("buffer data", `ASF_OFF_RXBUF, 32'h1ff, 32'h022);
    // transmit queue overrun and flush with the channel stopped
    wr(`ASF_OFF_CON, 32'h0);
    wr(`ASF_OFF_FLAGS, 32'h1);
    for (int i = 0; i < 10; i++) wr(`ASF_OFF_TXBUF, 32'h40 + i);
    rdc("tx full fill", `ASF_OFF_FSTAT, 32'hf00, 32'h800);
    rdc("tx overrun", `ASF_OFF_FLAGS, 32'h1, 32'h1);
    wr(`ASF_OFF_TX_FIFO_CONTROL, 32'h3);
    rdc("tx flushed", `ASF_OFF_FSTAT, 32'hf00, 32'h0);
    rdc("flush self clear", `ASF_OFF_TX_FIFO_CONTROL, 32'hf03, 32'h1);
    test_done();
  end
endmodule
